// ===== verif/gmr_host.sv
/*
  Host controller model that issues single register byte accesses.
  Assumes the bench calls xfer and shares sys_clk_i with the block.
*/
`timescale 1ns/1ns
module gmr_host (
  // Clock
  input wire logic sys_clk_i,
  // Register strobes
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_is_i2c_o
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_is_i2c_o = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic i);
    @(negedge sys_clk_i);
    reg_wr_o = w;
    reg_rd_o = !w;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_is_i2c_o = i;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // Released lines show the inverse so a stale value never looks valid.
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    reg_is_i2c_o = ~i;
  endtask
endmodule

// ===== verif/tb_gyro_mode_rate_control.sv
/*
  Self-checking bench for the mode and rate control register.
  Assumes a short sample base so tick periods stay brief.
*/
`timescale 1ns/1ns
module tb_gyro_mode_rate_control;
  import gmr_pkg::*;
  localparam int unsigned BASE = 8;
  logic sys_clk_i, sys_rst_i, wr, rd, i2c, pce, pin, pin_drv_n, pin_val;
  logic ack, nack, pull_up, st, ready, tick, srst;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] rate;
  gmr_mode_t mode;
  logic [9:0] exp_q[$];
  int errors, n_compared, cycles, k, n;

  // Weak pull-up resolves the released pin, else it floats to the inverse.
  assign pin = !pin_drv_n ? pin_val : (pull_up | !pin_val);

  gmr_host host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_is_i2c_o(i2c));
  gmr_ctrl #(.ODR_BASE(BASE)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_is_i2c_i(i2c), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_nack_o(nack),
    .pin_power_control_enable_i(pce), .shared_irq_power_pin_i(pin), .pull_up_en_o(pull_up),
    .mode_o(mode), .rate_select_o(rate), .self_test_o(st), .chain_ready_o(ready),
    .sample_tick_o(tick), .soft_reset_o(srst));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk_i);
  endtask

  task automatic acc(input logic w, input logic [7:0] d, input logic i, input logic [9:0] e);
    exp_q.push_back(e);
    host.xfer(w, 8'h13, d, i);
  endtask

  task automatic quiet();
    k = 0;
    repeat (600)
    begin
      cyc(1);
      if (tick !== 1'b0)
        k++;
    end
  endtask

  task automatic gap();
    repeat (2)
    begin
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end
      while (tick !== 1'b1 && n < 2000);
    end
  endtask

  // Every answer pops the oldest note; an unnoted answer can never match.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (ack === 1'b1 || nack === 1'b1)
      chk({ack, nack, rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff);
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    pce = 1'b0;
    pin_drv_n = 1'b0;
    pin_val = 1'b0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(32'h79c21598));
    cyc(12);
    sys_rst_i = 1'b0;
    acc(1'b0, 8'h00, 1'b0, 10'h200);
    cyc(3);
    chk(mode, GMR_STANDBY);
    for (int r = 0; r < 8; r++)
    begin
      v = 8'($urandom);
      v = {1'b1, 1'b0, v[0], r[2:0], 2'b01};
      acc(1'b1, v, 1'b0, 10'h200);
      acc(1'b0, 8'h00, 1'b0, {3'b100, v[6:0]});
      cyc(3);
      chk({ready, st, rate, mode}, {1'b1, v[5], r[2:0], GMR_READY});
    end
    quiet();
    chk(k, 0);
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, {6'h00, m[1:0]}, 1'b0, 10'h200);
      cyc(3);
      chk(mode, m[1] ? GMR_ACTIVE : (m[0] ? GMR_READY : GMR_STANDBY));
    end
    for (int r = 1; r < 8; r += 2)
    begin
      // Rate is changed in Ready first.
      acc(1'b1, {3'b000, r[2:0], 2'b01}, 1'b0, 10'h200);
      acc(1'b1, {3'b000, r[2:0], 2'b10}, 1'b0, 10'h200);
      gap();
      chk(n, BASE << (r > 6 ? 6 : r));
    end
    acc(1'b1, 8'h00, 1'b0, 10'h200);
    quiet();
    chk(k, 0);
    pce = 1'b1;
    acc(1'b1, 8'h02, 1'b0, 10'h200);
    cyc(3);
    chk({pull_up, mode}, {1'b1, GMR_STANDBY});
    pin_drv_n = 1'b1;
    cyc(3);
    chk(mode, GMR_ACTIVE);
    acc(1'b0, 8'h00, 1'b0, 10'h202);
    pin_drv_n = 1'b0;
    pce = 1'b0;
    cyc(3);
    chk({pull_up, mode}, {1'b0, GMR_STANDBY});
    acc(1'b1, 8'h35, 1'b0, 10'h200);
    acc(1'b1, 8'h40, 1'b0, 10'h200);
    host.xfer(1'b0, 8'h13, 8'h00, 1'b0);
    k = 0;
    repeat (8)
    begin
      cyc(1);
      if (srst === 1'b1)
        k++;
    end
    chk(k, 1);
    chk({st, rate, mode}, 6'h00);
    acc(1'b1, 8'h35, 1'b0, 10'h200);
    acc(1'b1, 8'h40, 1'b1, 10'h100);
    cyc(8);
    acc(1'b0, 8'h00, 1'b0, 10'h200);
    host.xfer(1'b1, 8'h14, 8'hff, 1'b0);
    host.xfer(1'b0, 8'h12, 8'h00, 1'b0);
    acc(1'b0, 8'h00, 1'b0, 10'h200);
    cyc(5);
    chk(exp_q.size(), 0);
    give_verdict();
  end
endmodule

// ===== verilog/gmr_ctrl.sv
/*
  Mode and rate control register of the angular rate sensor.
  Holds rate select, mode bits, self-test and the self-clearing soft reset.
  Assumes the serial front end presents one-cycle read and write strobes
  with a byte address, and that the power pin level is already synchronous.
*/
// Function
// - Writing the reset bit resets the device and restores register defaults.
// - The reset bit clears itself; reads are dropped while a reset is under way, so it always reads zero.
// - A reset written over I2C is not acknowledged.
// - The self-test bit drives a stimulus into the chain while set.
// - The rate field picks 800 down to 25 Hz, with codes six and seven at 12.5 Hz.
// - The run bit selects Active, else the warm bit selects Ready, else Standby.
// - Standby does communication only and no measurement.
// - Ready prepares the chain but takes no samples.
// - Active samples at the selected output data rate.
// - With pin power control on, the run bit follows the pin and ignores writes.
// - Pin power control turns on a weak pull-up so a floating pin means Active.
`timescale 1ns/1ns
module gmr_ctrl #(
  parameter int unsigned ODR_BASE = gmr_pkg::ODR_BASE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register access from the serial front end
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_is_i2c_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_nack_o,
  // Power pin control
  input wire logic pin_power_control_enable_i,
  input wire logic shared_irq_power_pin_i,
  output logic pull_up_en_o,
  // Measurement chain control
  output gmr_pkg::gmr_mode_t mode_o,
  output logic [2:0] rate_select_o,
  output logic self_test_o,
  output logic chain_ready_o,
  output logic sample_tick_o,
  output logic soft_reset_o
);
  import gmr_pkg::*;

  logic run_bit;
  logic warm_bit;
  logic self_test_bit;
  logic [2:0] rate_select;
  logic rst_pending;
  logic [2:0] rst_cnt;
  logic wr_hit;
  logic rd_hit;
  logic soft_req;
  logic soft_done;
  logic run_eff;
  logic [7:0] readback;
  gmr_mode_t next_mode;

  gmr_meas_if meas ();

  gmr_odr_timer #(
    .ODR_BASE(ODR_BASE)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .meas(meas)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Accesses during a pending reset are dropped; the device is busy.
  assign wr_hit = reg_wr_i && reg_addr_i == MRC_OFFSET && !rst_pending;
  assign rd_hit = reg_rd_i && reg_addr_i == MRC_OFFSET && !rst_pending;
  assign soft_req = wr_hit && reg_wdata_i[RST_BIT];
  assign soft_done = rst_pending && rst_cnt == 3'h0;
  assign run_eff = pin_power_control_enable_i ? shared_irq_power_pin_i : run_bit;
  assign readback = {1'b0, rst_pending, self_test_bit, rate_select, run_eff, warm_bit};
  assign next_mode = rst_pending ? GMR_STANDBY : gmr_mode_decode(run_eff, warm_bit);

  // ---------------------------------------------------------------
  // Soft reset sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rst_pending <= 1'b0;
      rst_cnt <= 3'h0;
    end
    else if (soft_req)
    begin
      rst_pending <= 1'b1;
      rst_cnt <= SOFT_RST_CYCLES - 3'h1;
    end
    else if (soft_done)
    begin
      rst_pending <= 1'b0;
    end
    else if (rst_pending)
    begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || soft_done)
    begin
      {self_test_bit, rate_select, run_bit, warm_bit} <= MRC_RESET[5:0];
    end
    else if (wr_hit && !reg_wdata_i[RST_BIT])
    begin
      self_test_bit <= reg_wdata_i[ST_BIT];
      rate_select <= reg_wdata_i[RATE_MSB:RATE_LSB];
      warm_bit <= reg_wdata_i[WARM_BIT];
      if (!pin_power_control_enable_i)
      begin
        run_bit <= reg_wdata_i[RUN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register answers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_ack_o <= 1'b0;
      reg_nack_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_ack_o <= rd_hit || (wr_hit && !(soft_req && reg_is_i2c_i));
      reg_nack_o <= soft_req && reg_is_i2c_i;
      reg_rdata_o <= rd_hit ? readback : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Chain control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_o <= GMR_STANDBY;
      meas.mode <= GMR_STANDBY;
      meas.rate <= 3'h0;
      rate_select_o <= 3'h0;
      self_test_o <= 1'b0;
      chain_ready_o <= 1'b0;
      sample_tick_o <= 1'b0;
      soft_reset_o <= 1'b0;
      pull_up_en_o <= 1'b0;
    end
    else
    begin
      mode_o <= next_mode;
      meas.mode <= next_mode;
      meas.rate <= rate_select;
      rate_select_o <= rate_select;
      self_test_o <= self_test_bit;
      chain_ready_o <= next_mode != GMR_STANDBY;
      sample_tick_o <= meas.tick;
      soft_reset_o <= soft_done;
      pull_up_en_o <= pin_power_control_enable_i;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_reset_busy;
    rst_pending [*4];
  endsequence

  sequence s_reset_over;
    !rst_pending && {self_test_bit, rate_select, run_bit, warm_bit} == 6'h00;
  endsequence

  a_soft_reset_defaults: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_req |=> s_reset_busy ##1 s_reset_over) else $error("soft reset left fields set");

  a_reset_bit_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_req |=> ##4 !rst_pending && soft_reset_o)
    else $error("reset bit did not clear");

  a_i2c_reset_nack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_req && reg_is_i2c_i |=> !reg_ack_o && reg_nack_o) else $error("reset byte acked");

  a_self_test_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_hit && !reg_wdata_i[RST_BIT] |=> ##1 self_test_o == $past(reg_wdata_i[ST_BIT], 2))
    else $error("self-test output wrong");

  a_rate_field_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_hit && !reg_wdata_i[RST_BIT] |=> ##1 rate_select_o == $past(reg_wdata_i[4:2], 2))
    else $error("rate select not loaded");

  a_run_gives_active: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    run_eff && !rst_pending |=> mode_o == GMR_ACTIVE) else $error("run bit not active");

  a_standby_no_samples: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mode_o == GMR_STANDBY [*3] |-> !sample_tick_o && !chain_ready_o)
    else $error("sampling in standby");

  a_ready_no_samples: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mode_o == GMR_READY [*3] |-> !sample_tick_o && chain_ready_o)
    else $error("sampling in ready");

  a_pin_blocks_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pin_power_control_enable_i && wr_hit && !soft_req |=> run_bit == $past(run_bit))
    else $error("run bit written under pin control");

  a_pull_up_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pin_power_control_enable_i |=> pull_up_en_o) else $error("pull-up not enabled");

  a_reserved_reads_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_hit |=> reg_ack_o && reg_rdata_o[RSV_BIT] == 1'b0) else $error("reserved bit set");

  // ---------------------------------------------------------------
  // Standby dwell counter
  // ---------------------------------------------------------------
  // A long standby check is counted here rather than unrolled in a property.
  logic [3:0] idle_cnt;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || mode_o != GMR_STANDBY)
    begin
      idle_cnt <= 4'h0;
    end
    else if (idle_cnt != 4'hf)
    begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  a_idle_no_tick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    idle_cnt >= 4'h3 |-> !sample_tick_o) else $error("tick after standby dwell");

  a_pending_standby: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rst_pending |=> mode_o == GMR_STANDBY) else $error("mode not standby in reset");

  a_reset_pulse_once: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_reset_o |=> !soft_reset_o) else $error("reset pulse too long");

  a_busy_refuses_access: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (reg_wr_i || reg_rd_i) && rst_pending |=> !reg_ack_o && !reg_nack_o)
    else $error("access answered while busy");

  a_spi_reset_acked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_req && !reg_is_i2c_i |=> reg_ack_o && !reg_nack_o) else $error("spi reset not acked");

  a_self_test_tracks: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    1'b1 |=> self_test_o == $past(self_test_bit)) else $error("self-test lags bit");

  a_warm_gives_ready: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !run_eff && warm_bit && !rst_pending |=> mode_o == GMR_READY)
    else $error("warm bit not ready");

  a_zero_gives_standby: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !run_eff && !warm_bit |=> mode_o == GMR_STANDBY) else $error("idle bits not standby");

  a_active_chain_on: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mode_o == GMR_ACTIVE |-> chain_ready_o) else $error("chain off in active");

  a_pin_sets_active: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pin_power_control_enable_i && shared_irq_power_pin_i && !rst_pending |=> mode_o == GMR_ACTIVE)
    else $error("pin did not select active");

endmodule

// ===== verilog/gmr_meas_if.sv
/*
  Carrier between the control register and the output data rate timer.
  Assumes both ends share sys_clk_i.
*/
`timescale 1ns/1ns
interface gmr_meas_if;
  import gmr_pkg::*;
  gmr_mode_t mode;
  logic [2:0] rate;
  logic tick;

  modport ctrl (output mode, output rate, input tick);
  modport timer (input mode, input rate, output tick);
endinterface

// ===== verilog/gmr_odr_timer.sv
/*
  Output data rate timer: one tick per sample period while Active.
  Assumes mode and rate come from registers in the control block.
*/
`timescale 1ns/1ns
module gmr_odr_timer #(
  parameter int unsigned ODR_BASE = gmr_pkg::ODR_BASE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Measurement side
  gmr_meas_if.timer meas
);
  import gmr_pkg::*;

  logic [ODR_CNT_W-1:0] cnt;
  logic [2:0] last_rate;
  logic [2:0] shift;
  logic [ODR_CNT_W-1:0] period;

  // Codes six and seven share the slowest rate.
  assign shift = (meas.rate >= RATE_SHIFT_MAX) ? RATE_SHIFT_MAX : meas.rate;
  assign period = ODR_CNT_W'(ODR_BASE) << shift;

  // ---------------------------------------------------------------
  // Sample period counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    last_rate <= meas.rate;
    if (sys_rst_i || meas.mode != GMR_ACTIVE || meas.rate != last_rate)
    begin
      cnt <= '0;
      meas.tick <= 1'b0;
    end
    else if (cnt == period - 1'b1)
    begin
      cnt <= '0;
      meas.tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      meas.tick <= 1'b0;
    end
  end

  a_tick_needs_active: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    meas.tick |-> $past(meas.mode) == GMR_ACTIVE) else $error("tick outside active");

endmodule

// ===== verilog/gmr_pkg.sv
/*
  Constants and helpers for the mode and rate control register block.
  Assumes a 125 MHz system clock and one 8-bit register at a byte address.
*/
package gmr_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] MRC_OFFSET = 8'h13;
  localparam logic [7:0] MRC_RESET = 8'h00;
  localparam int RSV_BIT = 7;
  localparam int RST_BIT = 6;
  localparam int ST_BIT = 5;
  localparam int RATE_MSB = 4;
  localparam int RATE_LSB = 2;
  localparam int RUN_BIT = 1;
  localparam int WARM_BIT = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ODR_BASE_PERIOD_NS = 1250000;
  localparam int unsigned ODR_BASE_CYCLES = ODR_BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] SOFT_RST_CYCLES = 3'h4;
  localparam logic [2:0] RATE_SHIFT_MAX = 3'h6;
  localparam int ODR_CNT_W = 24;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    GMR_STANDBY = 2'b00,
    GMR_READY = 2'b01,
    GMR_ACTIVE = 2'b10
  } gmr_mode_t;

  // The run bit outranks the warm bit.
  function automatic gmr_mode_t gmr_mode_decode(input logic run, input logic warm);
    gmr_mode_t m;
    m = GMR_STANDBY;
    if (run)
    begin
      m = GMR_ACTIVE;
    end
    else if (warm)
    begin
      m = GMR_READY;
    end
    return m;
  endfunction

endpackage
